// ---- src/pcs_cfg_pkg.sv ----
// Package: register map, field positions, reset values and carrier types
package pcs_cfg_pkg;

  // ****************************************************************
  // Register map (printed offsets are word indices, byte addr = 4*idx)
  // ****************************************************************
  localparam logic [7:0] IDX_RX_ERR_COUNT = 8'h15;
  localparam logic [7:0] IDX_CODING_CFG = 8'h16;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h1A;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h1B;
  localparam logic [9:0] ADDR_RX_ERR_COUNT = {IDX_RX_ERR_COUNT, 2'b00};
  localparam logic [9:0] ADDR_CODING_CFG = {IDX_CODING_CFG, 2'b00};
  localparam logic [9:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int BIT_BLOCK_CODE_SKIP = 12;
  localparam int BIT_FREE_RX_CLOCK = 11;
  localparam int BIT_QUIET_TX = 10;
  localparam int BIT_FORCE_SD = 9;
  localparam int BIT_SD_ALGO = 8;
  localparam int BIT_FORCE_LINK_100 = 5;
  localparam int BIT_NRZI_SKIP = 2;
  localparam int BIT_TX_SCRAM_SKIP = 1;
  localparam int BIT_RX_DESCRAM_SKIP = 0;
  localparam logic [15:0] CFG_WRITABLE = 16'h1F27;
  localparam logic [15:0] CFG_RESET = 16'h0100;
  localparam logic [7:0] TALLY_RESET = 8'h00;
  localparam logic [7:0] TALLY_MAX = 8'hFF;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam int IRQ_ERR_EVENT = 0;
  localparam int IRQ_SATURATED = 1;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // Coding path controls as one carrier
  typedef struct packed {
    logic block_code_skip;
    logic free_rx_clock;
    logic quiet_transmit_enable;
    logic force_signal_detect;
    logic signal_detect_algo_sel;
    logic force_link_100;
    logic nrzi_skip;
    logic tx_scrambler_skip;
    logic rx_descrambler_skip;
  } coding_ctrl_t;

  // Receive symbol status from the PCS
  typedef struct packed {
    logic carrier_valid;
    logic symbol_invalid;
    logic collision;
  } rx_status_t;

endpackage : pcs_cfg_pkg

// ---- src/pcs_config_rx_error_counter.sv ----
// Coding path configuration and saturating receive error tally, Avalon-MM slave
//
// Behaviour
// R1: An 8-bit error tally sits in bits 7:0 of the receive error count register and counts receive errors.
// R2: An error is recognised only while carrier is valid and an invalid symbol is seen in it.
// R3: The tally moves at most once per carrier event however many bad symbols it holds.
// R4: A carrier event that saw a collision does not move the tally.
// R5: The tally sticks at its maximum and never wraps.
// R6: The tally resets to zero, can be written, and clears when software reads it.
// R7: Reserved upper bits of both registers ignore writes and read as zero.
// R8: Bit 12 set bypasses the 4B5B coding, clear keeps it, reset zero.
// R9: Bit 11 set makes the receive clock free-running, clear keeps it phase aligned.
// R10: Bit 10 set enables true quiet transmit, clear is normal transmit.
// R11: Bit 9 set forces signal detect in the attachment sublayer, clear is normal.
// R12: Bit 8, reset one, selects enhanced signal detect when set and reduced when clear.
// R13: Bit 5 set forces a good 100 Mb/s link, clear is normal link status.
// R14: Bit 2 set bypasses NRZI coding, clear keeps it.
// R15: Bit 1 set bypasses the transmit scrambler, clear keeps it.
// R16: Bit 0 set bypasses the receive descrambler, clear keeps it.
// R17: Software keeps reserved bits 6, 4 and 3 at zero and treats bit 7 as read-only zero.
`timescale 1ns/10ps
`default_nettype none
module pcs_config_rx_error_counter (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Receive status from the PCS
  input wire pcs_cfg_pkg::rx_status_t rx_status,
  // Coding path controls
  output pcs_cfg_pkg::coding_ctrl_t coding_ctrl,
  // Interrupt
  output logic irq
);

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  typedef enum logic {BUS_IDLE, BUS_DONE} bus_state_t;
  bus_state_t bus_state_reg;
  logic [15:0] cfg_reg;
  logic [7:0] tally_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic in_carrier_reg;
  logic seen_error_reg;
  logic seen_collision_reg;
  logic wr_take;
  logic rd_take;
  logic err_event;
  logic sat_event;
  logic [15:0] cfg_next;
  logic [7:0] tally_next;

  // Address compare shared by read and write decode
  function automatic logic hit(input logic [9:0] addr, input logic [9:0] target);
    hit = (addr == target);
  endfunction : hit

  // One wait cycle, then the access completes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bus_state_reg <= BUS_IDLE;
    end else begin
      unique case (bus_state_reg)
        BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state_reg <= BUS_DONE;
          end
        end
        BUS_DONE: begin
          bus_state_reg <= BUS_IDLE;
        end
      endcase
    end
  end

  // Waitrequest high except in the completing cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((bus_state_reg == BUS_IDLE) && (avs_read || avs_write));
    end
  end

  // Waitrequest stays low for one cycle only
  a_wait_one_cycle: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low twice");

  // Access takes effect on the edge where waitrequest is low
  assign wr_take = avs_write && !avs_waitrequest;
  assign rd_take = avs_read && !avs_waitrequest;

  // ****************************************************************
  // Coding path configuration
  // ****************************************************************
  // Byte-lane merge, reserved bits forced to zero
  always_comb begin
    cfg_next = cfg_reg;
    if (avs_byteenable[0]) begin
      cfg_next[7:0] = avs_writedata[7:0];
    end
    if (avs_byteenable[1]) begin
      cfg_next[15:8] = avs_writedata[15:8];
    end
    cfg_next = cfg_next & pcs_cfg_pkg::CFG_WRITABLE; // [R7] [R17]
  end

  // Configuration storage
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_reg <= pcs_cfg_pkg::CFG_RESET; // [R8] [R12]
    end else if (wr_take && hit(avs_address, pcs_cfg_pkg::ADDR_CODING_CFG)) begin
      cfg_reg <= cfg_next;
    end
  end

  // Reset values, and a full write lands on the writable bits only
  a_cfg_reset: assert property (@(posedge clk_sys) // [R6] [R8] [R12]
    $fell(sys_rst) |-> (cfg_reg == pcs_cfg_pkg::CFG_RESET) && (tally_reg == pcs_cfg_pkg::TALLY_RESET))
    else $error("register not at reset value");

  a_cfg_write_lands: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R7]
    (wr_take && hit(avs_address, pcs_cfg_pkg::ADDR_CODING_CFG) && (avs_byteenable[1:0] == 2'h3)) |=>
    (cfg_reg == {3'h0, $past(avs_writedata[12:8]), 2'h0, $past(avs_writedata[5]), 2'h0, $past(avs_writedata[2:0])}))
    else $error("config write lost");

  // Control outputs registered from the configuration
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      coding_ctrl <= '0;
      coding_ctrl.signal_detect_algo_sel <= pcs_cfg_pkg::CFG_RESET[pcs_cfg_pkg::BIT_SD_ALGO];
    end else begin
      coding_ctrl.block_code_skip <= cfg_reg[pcs_cfg_pkg::BIT_BLOCK_CODE_SKIP]; // [R8]
      coding_ctrl.free_rx_clock <= cfg_reg[pcs_cfg_pkg::BIT_FREE_RX_CLOCK]; // [R9]
      coding_ctrl.quiet_transmit_enable <= cfg_reg[pcs_cfg_pkg::BIT_QUIET_TX]; // [R10]
      coding_ctrl.force_signal_detect <= cfg_reg[pcs_cfg_pkg::BIT_FORCE_SD]; // [R11]
      coding_ctrl.signal_detect_algo_sel <= cfg_reg[pcs_cfg_pkg::BIT_SD_ALGO]; // [R12]
      coding_ctrl.force_link_100 <= cfg_reg[pcs_cfg_pkg::BIT_FORCE_LINK_100]; // [R13]
      coding_ctrl.nrzi_skip <= cfg_reg[pcs_cfg_pkg::BIT_NRZI_SKIP]; // [R14]
      coding_ctrl.tx_scrambler_skip <= cfg_reg[pcs_cfg_pkg::BIT_TX_SCRAM_SKIP]; // [R15]
      coding_ctrl.rx_descrambler_skip <= cfg_reg[pcs_cfg_pkg::BIT_RX_DESCRAM_SKIP]; // [R16]
    end
  end

  // Each control output follows its configuration bit one clock later
  a_ctrl_free_clock: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R9]
    1'b1 |=> (coding_ctrl.free_rx_clock == $past(cfg_reg[pcs_cfg_pkg::BIT_FREE_RX_CLOCK])))
    else $error("free clock control lags");

  a_ctrl_quiet_tx: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R10]
    1'b1 |=> (coding_ctrl.quiet_transmit_enable == $past(cfg_reg[pcs_cfg_pkg::BIT_QUIET_TX])))
    else $error("quiet transmit control lags");

  a_ctrl_force_sd: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R11]
    1'b1 |=> (coding_ctrl.force_signal_detect == $past(cfg_reg[pcs_cfg_pkg::BIT_FORCE_SD])))
    else $error("signal detect force lags");

  a_ctrl_force_link: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R13]
    1'b1 |=> (coding_ctrl.force_link_100 == $past(cfg_reg[pcs_cfg_pkg::BIT_FORCE_LINK_100])))
    else $error("link force control lags");

  a_ctrl_nrzi_skip: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R14]
    1'b1 |=> (coding_ctrl.nrzi_skip == $past(cfg_reg[pcs_cfg_pkg::BIT_NRZI_SKIP])))
    else $error("nrzi control lags");

  a_ctrl_scram_skip: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R15]
    1'b1 |=> (coding_ctrl.tx_scrambler_skip == $past(cfg_reg[pcs_cfg_pkg::BIT_TX_SCRAM_SKIP])))
    else $error("scrambler control lags");

  a_ctrl_descram_skip: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R16]
    1'b1 |=> (coding_ctrl.rx_descrambler_skip == $past(cfg_reg[pcs_cfg_pkg::BIT_RX_DESCRAM_SKIP])))
    else $error("descrambler control lags");

  // ****************************************************************
  // Carrier event tracking
  // ****************************************************************
  // Flags for the running carrier event, judged when carrier ends
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      in_carrier_reg <= 1'b0;
      seen_error_reg <= 1'b0;
      seen_collision_reg <= 1'b0;
    end else begin
      in_carrier_reg <= rx_status.carrier_valid;
      if (rx_status.carrier_valid) begin
        if (rx_status.symbol_invalid) begin
          seen_error_reg <= 1'b1; // [R2]
        end
        if (rx_status.collision) begin
          seen_collision_reg <= 1'b1; // [R4]
        end
      end else begin
        seen_error_reg <= 1'b0;
        seen_collision_reg <= 1'b0;
      end
    end
  end

  // One event per carrier that saw a bad symbol, at its falling edge, none if collided
  assign err_event = in_carrier_reg && !rx_status.carrier_valid && seen_error_reg && !seen_collision_reg; // [R3] [R4]
  assign sat_event = err_event && (tally_reg == pcs_cfg_pkg::TALLY_MAX - 8'h01);

  // ****************************************************************
  // Receive error tally
  // ****************************************************************
  // Saturating increment
  always_comb begin
    tally_next = tally_reg;
    if (err_event && (tally_reg != pcs_cfg_pkg::TALLY_MAX)) begin
      tally_next = tally_reg + 8'h01; // [R1] [R5]
    end
  end

  // Write loads; a read takes away the value it returned, so an event
  // counted while the read waited, or in its completing cycle, is kept
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tally_reg <= pcs_cfg_pkg::TALLY_RESET; // [R6]
    end else if (wr_take && hit(avs_address, pcs_cfg_pkg::ADDR_RX_ERR_COUNT) && avs_byteenable[0]) begin
      tally_reg <= avs_writedata[7:0]; // [R6]
    end else if (rd_take && hit(avs_address, pcs_cfg_pkg::ADDR_RX_ERR_COUNT)) begin
      tally_reg <= tally_reg - avs_readdata[7:0] + {7'h00, err_event}; // [R6]
    end else begin
      tally_reg <= tally_next;
    end
  end

  // Tally moves only on a counted event, a write or a read
  a_tally_holds: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R1] [R2]
    (!err_event && !wr_take && !rd_take) |=> $stable(tally_reg))
    else $error("tally moved without cause");

  a_tally_sticks: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R5]
    (tally_reg == pcs_cfg_pkg::TALLY_MAX && !rd_take && !wr_take) |=> (tally_reg == pcs_cfg_pkg::TALLY_MAX))
    else $error("tally left its maximum");

  a_tally_loads: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R6]
    (wr_take && hit(avs_address, pcs_cfg_pkg::ADDR_RX_ERR_COUNT) && avs_byteenable[0]) |=>
    (tally_reg == $past(avs_writedata[7:0])))
    else $error("tally write lost");

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  // Sticky status, write one to clear, set wins
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_status_reg <= pcs_cfg_pkg::IRQ_RESET;
    end else begin
      if (wr_take && hit(avs_address, pcs_cfg_pkg::ADDR_IRQ_STATUS) && avs_byteenable[0]) begin
        irq_status_reg <= (irq_status_reg & ~avs_writedata[1:0]) | {sat_event, err_event};
      end else begin
        irq_status_reg <= irq_status_reg | {sat_event, err_event};
      end
    end
  end

  // Mask register
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_mask_reg <= pcs_cfg_pkg::IRQ_RESET;
    end else if (wr_take && hit(avs_address, pcs_cfg_pkg::ADDR_IRQ_MASK) && avs_byteenable[0]) begin
      irq_mask_reg <= avs_writedata[1:0];
    end
  end

  // Interrupt level
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Status bits latch their events and drive the level output
  a_status_sets: assert property (@(posedge clk_sys) disable iff (sys_rst)
    err_event |=> irq_status_reg[pcs_cfg_pkg::IRQ_ERR_EVENT])
    else $error("error status not set");

  a_status_sat: assert property (@(posedge clk_sys) disable iff (sys_rst)
    sat_event |=> irq_status_reg[pcs_cfg_pkg::IRQ_SATURATED])
    else $error("saturation status not set");

  a_status_sticky: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (irq_status_reg[pcs_cfg_pkg::IRQ_ERR_EVENT] && !wr_take) |=> irq_status_reg[pcs_cfg_pkg::IRQ_ERR_EVENT])
    else $error("status dropped without clear");

  a_irq_raised: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (|(irq_status_reg & irq_mask_reg)) |=> irq)
    else $error("interrupt not raised");

  a_irq_masked: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (irq_mask_reg == 2'h0) |=> !irq)
    else $error("masked interrupt raised");

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Read mux registered in the waiting cycle, valid when waitrequest drops
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      avs_readdata <= pcs_cfg_pkg::UNMAPPED_READ;
    end else if (avs_read && avs_waitrequest) begin
      if (hit(avs_address, pcs_cfg_pkg::ADDR_RX_ERR_COUNT)) begin
        avs_readdata <= {24'h000000, tally_reg}; // [R7]
      end else if (hit(avs_address, pcs_cfg_pkg::ADDR_CODING_CFG)) begin
        avs_readdata <= {16'h0000, cfg_reg}; // [R7]
      end else if (hit(avs_address, pcs_cfg_pkg::ADDR_IRQ_STATUS)) begin
        avs_readdata <= {30'h0, irq_status_reg};
      end else if (hit(avs_address, pcs_cfg_pkg::ADDR_IRQ_MASK)) begin
        avs_readdata <= {30'h0, irq_mask_reg};
      end else begin
        avs_readdata <= pcs_cfg_pkg::UNMAPPED_READ;
      end
    end
  end

  // Reserved upper bits read as zero
  a_read_upper_zero: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R7]
    (avs_read && !avs_waitrequest) |-> (avs_readdata[31:16] == 16'h0000))
    else $error("upper read bits set");

  a_tally_upper_zero: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R7]
    (rd_take && hit(avs_address, pcs_cfg_pkg::ADDR_RX_ERR_COUNT)) |-> (avs_readdata[15:8] == 8'h00))
    else $error("tally upper byte set");

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_tally_no_wrap: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R5]
    (tally_reg == pcs_cfg_pkg::TALLY_MAX && !$past(wr_take) && !rd_take && !wr_take) |=> (tally_reg != 8'h00))
    else $error("tally wrapped");
  a_one_per_carrier: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R3]
    err_event |=> !err_event)
    else $error("two counts in one carrier");
  a_collision_blocks: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R4]
    (seen_collision_reg && in_carrier_reg && !rx_status.carrier_valid) |-> !err_event)
    else $error("collided carrier counted");
  a_error_needs_symbol: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R2]
    err_event |-> seen_error_reg)
    else $error("count without bad symbol");
  a_count_steps: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R1]
    (err_event && !rd_take && !wr_take && tally_reg != pcs_cfg_pkg::TALLY_MAX) |=> (tally_reg == $past(tally_reg) + 8'h01))
    else $error("tally did not step");
  a_read_clears: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R6]
    (rd_take && hit(avs_address, pcs_cfg_pkg::ADDR_RX_ERR_COUNT) && !err_event && !wr_take) |=>
    (tally_reg == (($past(avs_readdata[7:0]) == pcs_cfg_pkg::TALLY_MAX) ? 8'h00 : {7'h00, $past(err_event, 2)})))
    else $error("read did not clear");
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R7]
    (cfg_reg[15:13] == 3'h0) && (cfg_reg[7:6] == 2'h0) && (cfg_reg[4:3] == 2'h0))
    else $error("reserved config bit set");
  a_ctrl_follows: assert property (@(posedge clk_sys) disable iff (sys_rst) // [R12]
    ##1 (coding_ctrl.signal_detect_algo_sel == $past(cfg_reg[pcs_cfg_pkg::BIT_SD_ALGO])) && (coding_ctrl.block_code_skip == $past(cfg_reg[pcs_cfg_pkg::BIT_BLOCK_CODE_SKIP])))
    else $error("control output lags config");
  a_wait_bounded: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(avs_read || avs_write) |-> ##[0:2] !avs_waitrequest)
    else $error("waitrequest stuck");
  c_error_counted: cover property (@(posedge clk_sys) disable iff (sys_rst) err_event);
  c_saturated: cover property (@(posedge clk_sys) disable iff (sys_rst) sat_event);
  c_read_tally: cover property (@(posedge clk_sys) disable iff (sys_rst)
    rd_take && hit(avs_address, pcs_cfg_pkg::ADDR_RX_ERR_COUNT) && tally_reg != 8'h00);
  c_irq: cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(irq));
  c_cfg_written: cover property (@(posedge clk_sys) disable iff (sys_rst)
    wr_take && hit(avs_address, pcs_cfg_pkg::ADDR_CODING_CFG));

endmodule : pcs_config_rx_error_counter
`default_nettype wire

// ---- test/pcs_host_model.sv ----
// Management host model: Avalon-MM master with register access tasks
`timescale 1ns/10ps
`default_nettype none
module pcs_host_model (
  // Clock
  input wire logic clk_sys,
  // Avalon-MM master side
  output logic [9:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  // Idle bus at time zero
  initial begin
    avs_address = 10'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
  end

  // Holds the request until the edge that samples waitrequest low
  task automatic wait_answer();
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
  endtask : wait_answer

  // Write; the config register always gets bits 7, 6, 4 and 3 as zero
  task automatic reg_write(input logic [9:0] addr, input logic [15:0] data);
    logic [15:0] d;
    d = (addr == pcs_cfg_pkg::ADDR_CODING_CFG) ? (data & 16'hFF27) : data;
    @(posedge clk_sys);
    avs_address <= addr;
    avs_writedata <= {16'h0000, d};
    avs_write <= 1'b1;
    wait_answer();
    avs_write <= 1'b0;
  endtask : reg_write

  // Read; data taken at the edge where waitrequest is low
  task automatic reg_read(input logic [9:0] addr, output logic [31:0] data);
    @(posedge clk_sys);
    avs_address <= addr;
    avs_read <= 1'b1;
    wait_answer();
    data = avs_readdata;
    avs_read <= 1'b0;
  endtask : reg_read
endmodule : pcs_host_model
`default_nettype wire

// ---- test/test_pcs_config_rx_error_counter.sv ----
// Testbench for the coding path config and receive error tally block
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("mismatch %s expected %0h seen %0h", what, exp, got); end end
module test_pcs_config_rx_error_counter;
  localparam logic [9:0] A_CNT = pcs_cfg_pkg::ADDR_RX_ERR_COUNT;
  localparam logic [9:0] A_CFG = pcs_cfg_pkg::ADDR_CODING_CFG;
  localparam logic [9:0] A_STS = pcs_cfg_pkg::ADDR_IRQ_STATUS;
  localparam logic [9:0] A_MSK = pcs_cfg_pkg::ADDR_IRQ_MASK;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [9:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  pcs_cfg_pkg::rx_status_t rx_status = '0;
  pcs_cfg_pkg::coding_ctrl_t coding_ctrl;
  logic irq;
  int n_errors = 0;
  int cmp_count = 0;
  int cfg_bits[9] = '{12, 11, 10, 9, 8, 5, 2, 1, 0};
  logic [15:0] wdata;

  // ****************************************************************
  // Clock, design and host
  // ****************************************************************
  always #5 clk_sys = ~clk_sys;

  pcs_config_rx_error_counter i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_status(rx_status), .coding_ctrl(coding_ctrl), .irq(irq));

  pcs_host_model i_host (.clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  // Reads a register and compares the whole word
  task automatic rd(input logic [9:0] addr, input logic [31:0] exp, input string what);
    logic [31:0] v;
    i_host.reg_read(addr, v);
    `CHK(what, exp, v)
  endtask : rd

  // One carrier event; bad symbols in the first cycles, collision on the last
  task automatic carrier(input int len, input int nbad, input logic coll);
    for (int i = 0; i < len; i++) begin
      @(posedge clk_sys);
      rx_status <= '{carrier_valid: 1'b1, symbol_invalid: (i < nbad), collision: coll && (i == len - 1)};
    end
    @(posedge clk_sys);
    rx_status <= '0;
    repeat (3) @(posedge clk_sys);
  endtask : carrier

  // Prints counts and verdict, then stops
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    results();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    // Reset values
    rd(A_CFG, 32'h0000_0100, "cfg reset");
    rd(A_CNT, 32'h0000_0000, "tally reset");
    `CHK("ctrl reset", 9'h010, coding_ctrl)
    `CHK("irq reset", 1'b0, irq)
    // Walking one over every control bit
    foreach (cfg_bits[k]) begin
      wdata = 16'h0001 << cfg_bits[k];
      i_host.reg_write(A_CFG, wdata);
      rd(A_CFG, {16'h0000, wdata}, "cfg bit");
      `CHK("ctrl bit", {wdata[12:8], wdata[5], wdata[2:0]}, coding_ctrl)
    end
    // Reserved config bits 15:13 and tally bits 15:8 ignore writes
    i_host.reg_write(A_CFG, 16'hFFFF);
    rd(A_CFG, 32'h0000_1F27, "cfg reserved");
    `CHK("ctrl all", 9'h1FF, coding_ctrl)
    i_host.reg_write(A_CNT, 16'hABCD);
    rd(A_CNT, 32'h0000_00CD, "tally write");
    rd(A_CNT, 32'h0000_0000, "tally cleared");
    // Counted and refused carrier events
    carrier(3, 1, 1'b0);
    carrier(3, 1, 1'b1);
    carrier(4, 0, 1'b0);
    @(posedge clk_sys);
    rx_status <= '{carrier_valid: 1'b0, symbol_invalid: 1'b1, collision: 1'b0};
    @(posedge clk_sys);
    rx_status <= '0;
    carrier(5, 5, 1'b0);
    rd(A_CNT, 32'h0000_0002, "tally events");
    // Interrupt masked, unmasked, cleared
    `CHK("irq masked", 1'b0, irq)
    i_host.reg_write(A_MSK, 16'h0001);
    repeat (2) @(posedge clk_sys);
    `CHK("irq raised", 1'b1, irq)
    i_host.reg_write(A_STS, 16'h0001);
    repeat (2) @(posedge clk_sys);
    `CHK("irq cleared", 1'b0, irq)
    rd(A_STS, 32'h0000_0000, "status cleared");
    // Saturation
    i_host.reg_write(A_CNT, 16'h00FE);
    carrier(2, 1, 1'b0);
    carrier(2, 2, 1'b0);
    rd(A_CNT, 32'h0000_00FF, "tally saturated");
    rd(A_STS, 32'h0000_0003, "status saturated");
    // Event counted while a tally read waits is kept for the next read
    fork
      carrier(2, 1, 1'b0);
      begin
        repeat (2) @(posedge clk_sys);
        rd(A_CNT, 32'h0000_0000, "tally during event");
      end
    join
    rd(A_CNT, 32'h0000_0001, "tally event kept");
    // Unmapped places
    i_host.reg_write(A_CFG, 16'h0100);
    i_host.reg_write(10'h3F0, 16'hFFFF);
    rd(A_CFG, 32'h0000_0100, "cfg after unmapped");
    rd(10'h3FC, pcs_cfg_pkg::UNMAPPED_READ, "unmapped read");
    results();
  end
endmodule : test_pcs_config_rx_error_counter
`default_nettype wire
